// ---- hdl/ebr_pkg.sv ----
// Purpose: types shared by the block memory tile files
// Assumes: constants come from ebr_regs.svh
// Notes: nothing here is imported, every use is scoped
`include "ebr_regs.svh"

package ebr_pkg;
	typedef logic [3:0] ebr_width_t;
	typedef logic [2:0] ebr_mode_t;
	typedef logic [`EBR_ADDR_W-1:0] ebr_addr_t;
	typedef logic [`EBR_ROW_W-1:0] ebr_word_t;
	typedef logic [`EBR_ROW_IDX_W-1:0] ebr_row_t;
	typedef logic [`EBR_BE_W-1:0] ebr_be_t;
endpackage

// ---- hdl/ebr_port.sv ----
// Purpose: input register stage of one memory port
// Assumes: inputs synchronous to i_sys_clk
// Notes: these registers cannot be bypassed
module ebr_port (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// user side
	input wire ebr_pkg::ebr_addr_t i_addr,
	input wire logic i_addr_hold,
	input wire ebr_pkg::ebr_word_t i_data,
	input wire logic i_wren,
	input wire ebr_pkg::ebr_be_t i_byteen,
	input wire logic i_rden,
	// core side
	ebr_port_if.drive o_port
);
	ebr_pkg::ebr_addr_t addr_reg;
	ebr_pkg::ebr_addr_t addr_next;
	ebr_pkg::ebr_word_t data_reg;
	ebr_pkg::ebr_be_t be_reg;
	logic wren_reg;
	logic rden_reg;

	// stalled address lets a cache miss replay the same word
	assign addr_next = i_addr_hold ? addr_reg : i_addr;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			addr_reg <= '0;
			data_reg <= '0;
			be_reg <= '0;
			wren_reg <= 1'b0;
			rden_reg <= 1'b0;
		end else begin
			addr_reg <= addr_next;
			data_reg <= i_data;
			be_reg <= i_byteen;
			wren_reg <= i_wren;
			rden_reg <= i_rden;
		end
	end

	assign o_port.addr = addr_reg;
	assign o_port.data = data_reg;
	assign o_port.byteen = be_reg;
	assign o_port.wren = wren_reg;
	assign o_port.rden = rden_reg;
endmodule

// ---- hdl/ebr_port_if.sv ----
// Purpose: registered port inputs handed to the tile core
// Assumes: driven by one ebr_port instance
// Notes: all signals are flip-flop outputs
interface ebr_port_if;
	ebr_pkg::ebr_addr_t addr;
	ebr_pkg::ebr_word_t data;
	logic wren;
	ebr_pkg::ebr_be_t byteen;
	logic rden;

	modport drive (output addr, output data, output wren, output byteen, output rden);
	modport sample (input addr, input data, input wren, input byteen, input rden);
endinterface

// ---- hdl/ebr_regs.svh ----
// Purpose: constants of the embedded block memory tile
// Assumes: one clock, synchronous active-high reset
// Notes: array is 128 rows of four 9-bit lanes
`ifndef EBR_REGS_SVH
`define EBR_REGS_SVH

`define EBR_TOTAL_BITS 4608
`define EBR_ROWS 128
`define EBR_ROW_W 36
`define EBR_ROW_IDX_W 7
`define EBR_ADDR_W 12
`define EBR_BE_W 4
`define EBR_LANE_W 9
`define EBR_BYTE_W 8

// width codes, depth x width
`define EBR_W1 4'h0
`define EBR_W2 4'h1
`define EBR_W4 4'h2
`define EBR_W8 4'h3
`define EBR_W9 4'h4
`define EBR_W16 4'h5
`define EBR_W18 4'h6
`define EBR_W32 4'h7
`define EBR_W36 4'h8

// memory mode codes
`define EBR_MODE_SINGLE 3'h0
`define EBR_MODE_SIMPLE 3'h1
`define EBR_MODE_TRUE 3'h2
`define EBR_MODE_ROM 3'h3
`define EBR_MODE_FIFO 3'h4

`endif

// ---- hdl/ebr_tile.sv ----
// Purpose: embedded block memory tile, two ports, configurable shape
// Assumes: one clock; user logic drives both ports and the load port
// Notes: storage is flip-flops, 128 rows of four 9-bit lanes
// Functional notes
// - write and read inputs are always registered, the output register may be bypassed.
// - the array holds 4,608 bits including the parity bits.
// - shapes are 4Kx1 to 128x36, and the 128-deep shapes are refused in true dual-port mode.
// - modes are true dual-port, simple dual-port, single-port, ROM and FIFO store, with or without parity.
// - a ninth bit is stored beside every byte, and user logic makes and checks the parity.
// - byte enables mask writes at every width, and masked bytes keep their old contents.
// - two single-port memories of at most half size may share the tile on the one clock.
// - while the address clock enable is held the address register keeps its value.
// - a read of the address the same port writes returns the new data.
// - a read of the address the other port writes returns the old data.
// - in RAM and ROM modes the contents can be preloaded before operation starts.
//
`include "ebr_regs.svh"

module ebr_tile (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// configuration
	input wire ebr_pkg::ebr_mode_t i_mode,
	input wire logic i_packed,
	input wire ebr_pkg::ebr_width_t i_width_a,
	input wire ebr_pkg::ebr_width_t i_width_b,
	input wire logic i_outreg_a,
	input wire logic i_outreg_b,
	// preload port
	input wire logic i_load_we,
	input wire ebr_pkg::ebr_row_t i_load_row,
	input wire ebr_pkg::ebr_word_t i_load_word,
	// port a
	input wire ebr_pkg::ebr_addr_t i_addr_a,
	input wire logic i_addr_hold_a,
	input wire ebr_pkg::ebr_word_t i_data_a,
	input wire logic i_wren_a,
	input wire ebr_pkg::ebr_be_t i_byteen_a,
	input wire logic i_rden_a,
	input wire logic i_clr_a,
	// port b
	input wire ebr_pkg::ebr_addr_t i_addr_b,
	input wire logic i_addr_hold_b,
	input wire ebr_pkg::ebr_word_t i_data_b,
	input wire logic i_wren_b,
	input wire ebr_pkg::ebr_be_t i_byteen_b,
	input wire logic i_rden_b,
	input wire logic i_clr_b,
	// read data
	output ebr_pkg::ebr_word_t o_q_a,
	output ebr_pkg::ebr_word_t o_q_b,
	// status
	output logic o_cfg_err_a,
	output logic o_cfg_err_b
);
	// word width in bits, parity lanes counted
	function automatic int unsigned width_of(input ebr_pkg::ebr_width_t wc);
		int unsigned w;
		w = 1;
		case (wc)
			`EBR_W1: w = 1;
			`EBR_W2: w = 2;
			`EBR_W4: w = 4;
			`EBR_W8: w = 8;
			`EBR_W9: w = 9;
			`EBR_W16: w = 16;
			`EBR_W18: w = 18;
			`EBR_W32: w = 32;
			`EBR_W36: w = 36;
			default: w = 1;
		endcase
		return w;
	endfunction

	// shapes that carry the parity bit of each byte
	function automatic logic is_par(input ebr_pkg::ebr_width_t wc);
		return (wc == `EBR_W9) || (wc == `EBR_W18) || (wc == `EBR_W36);
	endfunction

	// address bits that select a word inside one row
	function automatic int unsigned lane_bits(input ebr_pkg::ebr_width_t wc);
		int unsigned lb;
		lb = 0;
		case (wc)
			`EBR_W1: lb = 5;
			`EBR_W2: lb = 4;
			`EBR_W4: lb = 3;
			`EBR_W8: lb = 2;
			`EBR_W9: lb = 2;
			`EBR_W16: lb = 1;
			`EBR_W18: lb = 1;
			default: lb = 0;
		endcase
		return lb;
	endfunction

	// shapes that are illegal for the selected mode
	function automatic logic shape_bad(input ebr_pkg::ebr_width_t wc, input ebr_pkg::ebr_mode_t md);
		logic bad;
		bad = (wc > `EBR_W36);
		if (md == `EBR_MODE_TRUE && (wc == `EBR_W32 || wc == `EBR_W36)) begin
			bad = 1'b1;
		end
		return bad;
	endfunction

	// position in the row of word bit i; data bits skip the parity lane
	function automatic int unsigned phys_bit(input ebr_pkg::ebr_width_t wc, input int unsigned lane,
			input int unsigned i);
		int unsigned d;
		d = lane * width_of(wc) + i;
		if (is_par(wc)) begin
			return d;
		end
		return (d / `EBR_BYTE_W) * `EBR_LANE_W + (d % `EBR_BYTE_W);
	endfunction

	// spread a port word and its byte enables over one row
	function automatic logic [2*`EBR_ROW_W-1:0] place(input ebr_pkg::ebr_width_t wc,
			input int unsigned lane, input ebr_pkg::ebr_word_t data, input ebr_pkg::ebr_be_t be);
		ebr_pkg::ebr_word_t mask;
		ebr_pkg::ebr_word_t val;
		int unsigned p;
		int unsigned bi;
		mask = '0;
		val = '0;
		for (int unsigned i = 0; i < `EBR_ROW_W; i++) begin
			if (i < width_of(wc)) begin
				p = phys_bit(wc, lane, i);
				bi = is_par(wc) ? i / `EBR_LANE_W : i / `EBR_BYTE_W;
				if (p < `EBR_ROW_W && bi < `EBR_BE_W) begin
					mask[p] = be[bi];
					val[p] = data[i];
				end
			end
		end
		return {mask, val};
	endfunction

	// gather one port word out of a row, upper bits zero
	function automatic ebr_pkg::ebr_word_t extract(input ebr_pkg::ebr_width_t wc,
			input int unsigned lane, input ebr_pkg::ebr_word_t row);
		ebr_pkg::ebr_word_t q;
		int unsigned p;
		q = '0;
		for (int unsigned i = 0; i < `EBR_ROW_W; i++) begin
			if (i < width_of(wc)) begin
				p = phys_bit(wc, lane, i);
				if (p < `EBR_ROW_W) begin
					q[i] = row[p];
				end
			end
		end
		return q;
	endfunction

	// row that holds a word; packed mode forces the top row bit
	function automatic ebr_pkg::ebr_row_t row_of(input ebr_pkg::ebr_width_t wc, input ebr_pkg::ebr_addr_t ad,
			input logic pk, input logic hi);
		ebr_pkg::ebr_addr_t sh;
		sh = ad >> lane_bits(wc);
		if (pk) begin
			return {hi, sh[`EBR_ROW_IDX_W-2:0]};
		end
		return sh[`EBR_ROW_IDX_W-1:0];
	endfunction

	// word slot inside the row, taken from the low address bits
	function automatic int unsigned lane_of(input ebr_pkg::ebr_width_t wc, input ebr_pkg::ebr_addr_t ad);
		int unsigned msk;
		msk = (32'd1 << lane_bits(wc)) - 32'd1;
		return 32'(ad) & msk;
	endfunction

	// registered port inputs
	ebr_port_if port_a ();
	ebr_port_if port_b ();

	ebr_port u_port_a (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_addr(i_addr_a),
		.i_addr_hold(i_addr_hold_a),
		.i_data(i_data_a),
		.i_wren(i_wren_a),
		.i_byteen(i_byteen_a),
		.i_rden(i_rden_a),
		.o_port(port_a.drive)
	);

	ebr_port u_port_b (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_addr(i_addr_b),
		.i_addr_hold(i_addr_hold_b),
		.i_data(i_data_b),
		.i_wren(i_wren_b),
		.i_byteen(i_byteen_b),
		.i_rden(i_rden_b),
		.o_port(port_b.drive)
	);

	// storage, never reset: 128 rows x 36 bits
	ebr_pkg::ebr_word_t mem_reg [0:`EBR_ROWS-1];

	// row and lane decode
	logic pack_on;
	ebr_pkg::ebr_row_t row_a;
	ebr_pkg::ebr_row_t row_b;
	logic [31:0] lane_a;
	logic [31:0] lane_b;

	assign pack_on = i_packed && (i_mode == `EBR_MODE_SINGLE);
	// packed halves: port a owns the low rows, port b the high rows
	assign row_a = row_of(i_width_a, port_a.addr, pack_on, 1'b0);
	assign row_b = row_of(i_width_b, port_b.addr, pack_on, 1'b1);
	assign lane_a = lane_of(i_width_a, port_a.addr);
	assign lane_b = lane_of(i_width_b, port_b.addr);

	// mode steering: which port may write
	logic err_a;
	logic err_b;
	logic a_may_write;
	logic b_may_write;
	logic wr_a;
	logic wr_b;

	assign err_a = shape_bad(i_width_a, i_mode);
	assign err_b = shape_bad(i_width_b, i_mode);
	assign a_may_write = (i_mode != `EBR_MODE_ROM) && (i_mode <= `EBR_MODE_FIFO);
	assign b_may_write = (i_mode == `EBR_MODE_TRUE) || pack_on;
	// a refused shape never touches the array
	assign wr_a = port_a.wren && a_may_write && !err_a;
	assign wr_b = port_b.wren && b_may_write && !err_b;

	// write placement
	logic [2*`EBR_ROW_W-1:0] put_a;
	logic [2*`EBR_ROW_W-1:0] put_b;
	ebr_pkg::ebr_word_t mask_a;
	ebr_pkg::ebr_word_t val_a;
	ebr_pkg::ebr_word_t mask_b;
	ebr_pkg::ebr_word_t val_b;

	assign put_a = place(i_width_a, lane_a, port_a.data, port_a.byteen);
	assign put_b = place(i_width_b, lane_b, port_b.data, port_b.byteen);
	assign mask_a = put_a[2*`EBR_ROW_W-1:`EBR_ROW_W];
	assign val_a = put_a[`EBR_ROW_W-1:0];
	assign mask_b = put_b[2*`EBR_ROW_W-1:`EBR_ROW_W];
	assign val_b = put_b[`EBR_ROW_W-1:0];

	// old contents of each addressed row
	ebr_pkg::ebr_word_t old_a;
	ebr_pkg::ebr_word_t old_b;

	assign old_a = mem_reg[row_a];
	assign old_b = mem_reg[row_b];

	// own write merged into the row, unwritten bytes kept
	ebr_pkg::ebr_word_t new_a;
	ebr_pkg::ebr_word_t own_b;
	logic same_row;
	ebr_pkg::ebr_word_t base_b;
	ebr_pkg::ebr_word_t new_b;

	assign new_a = (old_a & ~mask_a) | (val_a & mask_a);
	assign own_b = (old_b & ~mask_b) | (val_b & mask_b);
	// both ports on one row: b is merged over a so neither loses bits
	assign same_row = wr_a && (row_a == row_b);
	assign base_b = same_row ? new_a : old_b;
	assign new_b = (base_b & ~mask_b) | (val_b & mask_b);

	// array update; the preload port has priority over user writes
	always_ff @(posedge i_sys_clk) begin
		if (i_load_we) begin
			mem_reg[i_load_row] <= i_load_word;
		end else begin
			if (wr_a) begin
				mem_reg[row_a] <= new_a;
			end
			if (wr_b) begin
				mem_reg[row_b] <= new_b;
			end
		end
	end

	// read views: own write seen, the other port's write not
	ebr_pkg::ebr_word_t view_a;
	ebr_pkg::ebr_word_t view_b;
	ebr_pkg::ebr_word_t raw_a;
	ebr_pkg::ebr_word_t raw_b;

	assign view_a = wr_a ? new_a : old_a;
	assign view_b = wr_b ? own_b : old_b;
	assign raw_a = extract(i_width_a, lane_a, view_a);
	assign raw_b = extract(i_width_b, lane_b, view_b);

	// optional output registers
	ebr_pkg::ebr_word_t q_a_reg;
	ebr_pkg::ebr_word_t q_a_next;
	ebr_pkg::ebr_word_t q_b_reg;
	ebr_pkg::ebr_word_t q_b_next;

	// clear touches only these, never the array or input stage
	assign q_a_next = i_clr_a ? '0 : (port_a.rden ? raw_a : q_a_reg);
	assign q_b_next = i_clr_b ? '0 : (port_b.rden ? raw_b : q_b_reg);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			q_a_reg <= '0;
			q_b_reg <= '0;
		end else begin
			q_a_reg <= q_a_next;
			q_b_reg <= q_b_next;
		end
	end

	// bypass trades a cycle of latency for a longer path out
	assign o_q_a = i_outreg_a ? q_a_reg : raw_a;
	assign o_q_b = i_outreg_b ? q_b_reg : raw_b;
	assign o_cfg_err_a = err_a;
	assign o_cfg_err_b = err_b;
endmodule

// ---- verification/ebr_tile_chk.sv ----
// Purpose: port checks of the block memory tile
// Assumes: one clock, sync active-high reset
// Notes: the hold check needs a fixed shape
`include "ebr_regs.svh"

module ebr_tile_chk (
	// watched inputs
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire ebr_pkg::ebr_mode_t i_mode,
	input wire logic i_packed,
	input wire ebr_pkg::ebr_width_t i_width_a,
	input wire ebr_pkg::ebr_width_t i_width_b,
	input wire logic i_outreg_a,
	input wire logic i_load_we,
	input wire logic i_addr_hold_a,
	input wire logic i_wren_a,
	input wire logic i_wren_b,
	input wire logic i_rden_a,
	input wire logic i_clr_a,
	// watched outputs
	input wire ebr_pkg::ebr_word_t o_q_a,
	input wire logic o_cfg_err_a,
	input wire logic o_cfg_err_b
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	AST_CFG_TRUE_A: assert property (i_mode == `EBR_MODE_TRUE && i_width_a > `EBR_W18 |-> o_cfg_err_a)
		else $error("wide shape taken");
	AST_CFG_OK_A: assert property (i_mode != `EBR_MODE_TRUE && i_width_a <= `EBR_W36 |-> !o_cfg_err_a)
		else $error("legal shape a refused");
	AST_CFG_OK_B: assert property (i_mode != `EBR_MODE_TRUE && i_width_b <= `EBR_W36 |-> !o_cfg_err_b)
		else $error("legal shape b refused");
	AST_CFG_CODE_B: assert property (i_width_b > `EBR_W36 |-> o_cfg_err_b)
		else $error("bad code b taken");
	AST_RST_Q_A: assert property ($fell(i_rst) && i_outreg_a |-> o_q_a == '0)
		else $error("output not zero after reset");
	AST_CLR_Q_A: assert property (i_clr_a && !$past(i_rden_a) ##1 i_outreg_a |-> o_q_a == '0)
		else $error("clear missed");
	// output register changes only on a registered read, a clear or a reset
	AST_HOLD_Q_A: assert property (
		!$past(i_rden_a, 2) && !$past(i_clr_a) && !$past(i_rst) && $past(i_outreg_a) && i_outreg_a
		|-> $stable(o_q_a))
		else $error("output register moved");
	// a registered write in the held cycle shows its new data, so it is excluded too
	AST_ADDR_HOLD_A: assert property (
		$past(i_addr_hold_a) && !$past(i_outreg_a) && !i_outreg_a && !$past(i_load_we) && !$past(i_wren_a)
		&& !$past(i_wren_a, 2) && !$past(i_wren_b, 2) && $stable(i_mode) && $stable(i_width_a)
		&& $stable(i_packed) && !$past(i_rst) |-> $stable(o_q_a))
		else $error("held address moved");

	cover property (i_addr_hold_a);
	cover property (i_clr_a && i_outreg_a);
	cover property (i_wren_a && i_rden_a);
endmodule

bind ebr_tile ebr_tile_chk u_ebr_tile_chk (.i_sys_clk, .i_rst, .i_mode, .i_packed, .i_width_a, .i_width_b,
	.i_outreg_a, .i_load_we, .i_addr_hold_a, .i_wren_a, .i_wren_b, .i_rden_a, .i_clr_a,
	.o_q_a, .o_cfg_err_a, .o_cfg_err_b);

// ---- verification/ebr_user_model.sv ----
// Purpose: fabric user logic making and checking byte parity
// Assumes: even parity over each 9-bit lane
// Notes: combinational only
module ebr_user_model (
	// user side
	input wire logic [31:0] i_bytes,
	input wire ebr_pkg::ebr_word_t i_word,
	// tile side
	output wire ebr_pkg::ebr_word_t o_word,
	output wire logic o_par_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [3:0] lane_bad;
	for (genvar k = 0; k < 4; k++) begin : g_lane
		assign o_word[9*k +: 9] = {^i_bytes[8*k +: 8], i_bytes[8*k +: 8]};
		assign lane_bad[k] = ^i_word[9*k +: 9];
	end
	assign o_par_bad = |lane_bad;
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the block memory tile
// Assumes: x36 shape, a word is one row, except one x8 pass and a closing sweep of every width code
// Notes: a behavioural array mirrors the tile
`include "ebr_regs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_rst = 1, i_packed = 0, i_outreg_a = 1, i_outreg_b = 0, i_load_we = 0;
	logic i_addr_hold_a = 0, i_addr_hold_b = 0, i_wren_a = 0, i_wren_b = 0, i_rden_a = 0, i_rden_b = 0;
	logic i_clr_a = 0, i_clr_b = 0, o_cfg_err_a, o_cfg_err_b, par_bad;
	ebr_pkg::ebr_mode_t i_mode = `EBR_MODE_SIMPLE;
	ebr_pkg::ebr_width_t i_width_a = `EBR_W36, i_width_b = `EBR_W36;
	ebr_pkg::ebr_row_t i_load_row = '0;
	ebr_pkg::ebr_word_t i_load_word = '0, i_data_b = '0, i_data_a, o_q_a, o_q_b;
	ebr_pkg::ebr_addr_t i_addr_a = '0, i_addr_b = '0;
	ebr_pkg::ebr_be_t i_byteen_a = '1, i_byteen_b = '1;
	logic [31:0] bytes = '0;
	logic [35:0] mem [128];
	int bad_count = 0, n_compared = 0;

	ebr_tile u_ebr_tile (.*);
	ebr_user_model u_ebr_user_model (.i_bytes(bytes), .i_word(o_q_a), .o_word(i_data_a), .o_par_bad(par_bad));

	initial forever #4 i_sys_clk = ~i_sys_clk;

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a hung run still reaches the verdict
	initial begin
		#400000;
		bad_count++;
		conclude;
	end

	initial begin
		int a, m;
		logic [35:0] w;
		void'($urandom(40583));
		repeat (4) @(posedge i_sys_clk);
		i_rst <= 0;
		@(posedge i_sys_clk) #1 chk(o_q_a, '0);
		for (a = 0; a < 128; a++) begin
			@(posedge i_sys_clk);
			mem[a] = {4'($urandom), $urandom};
			i_load_we <= 1;
			i_load_row <= 7'(a);
			i_load_word <= mem[a];
		end
		@(posedge i_sys_clk);
		i_load_we <= 0;
		i_outreg_a <= 0;
		for (a = 0; a < 128; a++) begin
			@(posedge i_sys_clk);
			i_addr_a <= 12'(a);
			@(posedge i_sys_clk) #1 chk(o_q_a, mem[a]);
		end
		// every byte-enable pattern, other port reading the same word
		for (m = 0; m < 16; m++) begin
			a = $urandom_range(127);
			@(posedge i_sys_clk);
			bytes <= $urandom;
			i_addr_a <= 12'(a);
			i_addr_b <= 12'(a);
			i_wren_a <= 1;
			i_rden_a <= 1;
			i_rden_b <= 1;
			i_byteen_a <= 4'(m);
			@(posedge i_sys_clk);
			i_wren_a <= 0;
			#1 chk(o_q_b, mem[a]);
			for (int k = 0; k < 4; k++)
				if (m[k])
					mem[a][9*k +: 9] = i_data_a[9*k +: 9];
			chk(o_q_a, mem[a]);
		end
		@(posedge i_sys_clk) #1 chk(36'(par_bad), '0);
		@(posedge i_sys_clk);
		i_addr_a <= 12'h003;
		@(posedge i_sys_clk);
		i_addr_hold_a <= 1;
		i_addr_a <= 12'h07f;
		@(posedge i_sys_clk) #1 chk(o_q_a, mem[3]);
		@(posedge i_sys_clk);
		i_addr_hold_a <= 0;
		@(posedge i_sys_clk) #1 chk(o_q_a, mem[127]);
		@(posedge i_sys_clk);
		i_outreg_a <= 1;
		i_addr_a <= 12'h005;
		@(posedge i_sys_clk);
		i_rden_a <= 0;
		i_addr_a <= 12'h006;
		@(posedge i_sys_clk) #1 chk(o_q_a, mem[5]);
		@(posedge i_sys_clk) #1 chk(o_q_a, mem[5]);
		@(posedge i_sys_clk);
		i_clr_a <= 1;
		@(posedge i_sys_clk);
		i_clr_a <= 0;
		i_rden_a <= 1;
		#1 chk(o_q_a, '0);
		@(posedge i_sys_clk);
		i_rden_a <= 0;
		@(posedge i_sys_clk) #1 chk(o_q_a, mem[6]);
		// write attempt in every mode, x36 is refused in true dual
		for (m = 0; m < 5; m++) begin
			a = $urandom_range(127);
			@(posedge i_sys_clk);
			i_mode <= 3'(m);
			i_outreg_a <= 0;
			i_addr_a <= 12'(a);
			bytes <= $urandom;
			i_wren_a <= 1;
			i_byteen_a <= '1;
			@(posedge i_sys_clk);
			i_wren_a <= 0;
			#1 chk(36'(o_cfg_err_a), 36'(m == 2));
			if (m != 2 && m != 3)
				mem[a] = i_data_a;
			@(posedge i_sys_clk) #1;
			if (m != 2)
				chk(o_q_a, mem[a]);
		end
		@(posedge i_sys_clk);
		w = {4'($urandom), $urandom};
		i_mode <= `EBR_MODE_SINGLE;
		i_packed <= 1;
		i_addr_a <= 12'h005;
		i_addr_b <= 12'h005;
		i_data_b <= w;
		i_wren_b <= 1;
		@(posedge i_sys_clk);
		i_wren_b <= 0;
		@(posedge i_sys_clk) #1 chk(o_q_b, w);
		chk(o_q_a, mem[5]);
		mem[64 + 5] = w;
		// byte shape: a writes, b reads the same word through its output register
		for (m = 0; m < 8; m++) begin
			a = $urandom_range(511);
			@(posedge i_sys_clk);
			i_mode <= `EBR_MODE_SIMPLE;
			i_packed <= 0;
			i_width_a <= `EBR_W8;
			i_width_b <= `EBR_W8;
			i_outreg_b <= 1;
			i_addr_a <= 12'(a);
			i_addr_b <= 12'(a);
			bytes <= $urandom;
			i_wren_a <= 1;
			@(posedge i_sys_clk);
			i_wren_a <= 0;
			#1 chk(o_q_a, 36'(i_data_a[7:0]));
			w = 36'(mem[a >> 2][9*(a%4) +: 8]);
			mem[a >> 2][9*(a%4) +: 8] = i_data_a[7:0];
			@(posedge i_sys_clk) #1 chk(o_q_b, w);
		end
		@(posedge i_sys_clk);
		i_clr_b <= 1;
		@(posedge i_sys_clk);
		i_clr_b <= 0;
		#1 chk(o_q_b, '0);
		for (m = 0; m < 16; m++) begin
			@(posedge i_sys_clk);
			i_mode <= `EBR_MODE_TRUE;
			i_packed <= 0;
			i_width_a <= 4'(m);
			i_width_b <= 4'(m);
			@(posedge i_sys_clk) #1 chk(36'(o_cfg_err_b), 36'(m > 6));
		end
		conclude;
	end
endmodule
